// ### rtl/dpl_consts.svh
// constants for the clock recovery loop
`ifndef DPL_CONSTS_SVH
`define DPL_CONSTS_SVH
// ==========================================
// command field codes
`define DPL_CMD_NULL    3'h0
`define DPL_CMD_SEARCH  3'h1
`define DPL_CMD_DISABLE 3'h2
`define DPL_CMD_RST_MIS 3'h3
`define DPL_CMD_SRC_BRG 3'h4
`define DPL_CMD_SRC_PIN 3'h5
`define DPL_CMD_FM      3'h6
`define DPL_CMD_NRZI    3'h7
// ==========================================
// counter landmarks
`define DPL_CNT_HOLD  5'h10
`define DPL_CNT_ADJ   5'h05
`define DPL_CNT_PRE   5'h04
`define DPL_CNT_SKIP  5'h06
`define DPL_CNT_DEC   5'h02
`define DPL_CNT_MAX   5'h1f
`define DPL_CNT_ZERO  5'h00
`define DPL_CNT_NC_LO 5'h0f
`define DPL_CNT_NC_HI 5'h10
`define DPL_FM_WIN_LO 5'h0c
`define DPL_FM_WIN_HI 5'h13
// ==========================================
// output decoder bit positions
`define DPL_BIT_NRZI 4
`define DPL_BIT_FM_A 3
`define DPL_BIT_FM_B 2
`endif

// ### rtl/dpl_pkg.sv
// types shared by the clock recovery loop
package dpl_pkg;
  // ==========================================
  // loop state, one-hot
  typedef enum logic [2:0] {
    DPL_OFF  = 3'h1,
    DPL_SRCH = 3'h2,
    DPL_RUN  = 3'h4
  } dpl_state_t;
  // pending count correction
  typedef enum logic [2:0] {
    DPL_C_NONE  = 3'h1,
    DPL_C_LONG  = 3'h2,
    DPL_C_SHORT = 3'h4
  } dpl_corr_t;
  // ==========================================
  // sampler state
  typedef struct packed {
    logic ref_prev;
    logic rxd_prev;
  } dpl_smp_t;
  // main loop state
  typedef struct packed {
    dpl_state_t st;
    logic [4:0] cnt;
    dpl_corr_t  corr_req;
    dpl_corr_t  corr_act;
    logic       dup_done;
    logic       src_brg;
    logic       fm;
    logic       win_seen;
    logic       miss_prev;
    logic       one_mis;
    logic       two_mis;
    logic       srch_pend;
    logic       rx_out;
    logic       tx_out;
  } dpl_core_t;
endpackage : dpl_pkg

// ### rtl/dpl_sampler.sv
// reference select and edge detectors
`timescale 1ns/1ps
module dpl_sampler (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // raw inputs
  input  wire logic baud_rate_gen,
  input  wire logic rx_tx_clock_pin,
  input  wire logic rxd,
  // to the core
  dpl_smp_if.smp    sif
);
  import dpl_pkg::*;
  dpl_smp_t s_reg;  // previous levels
  dpl_smp_t s_next; // next previous levels
  logic     ref_lvl; // selected reference
  // ==========================================
  // two-input source multiplexer
  always_comb begin
    ref_lvl = sif.src_brg ? baud_rate_gen : rx_tx_clock_pin;
    s_next.ref_prev = ref_lvl;
    s_next.rxd_prev = rxd;
    sif.ref_rise = ref_lvl & ~s_reg.ref_prev;
    // low phase marks the second half of a count
    sif.half2 = ~ref_lvl;
    // data edges only seen while loop enabled
    sif.rxd_edge = sif.enable & (rxd ^ s_reg.rxd_prev);
  end
  // ==========================================
  // previous level registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : dpl_sampler

// ### rtl/dpl_smp_if.sv
// link between loop core and input sampler
`timescale 1ns/1ps
interface dpl_smp_if;
  logic src_brg;  // reference select
  logic enable;   // edge detector on
  logic ref_rise; // reference rose
  logic half2;    // second half of count
  logic rxd_edge; // receive data toggled
  modport core (output src_brg, output enable,
                input ref_rise, input half2, input rxd_edge);
  modport smp  (input src_brg, input enable,
                output ref_rise, output half2, output rxd_edge);
endinterface : dpl_smp_if

// ### rtl/dpl_top.sv
// digital phase-locked loop for receive clock recovery
// Overview of operation
// - reference runs 32x NRZI, 16x FM
// - 5-bit counter, edge detector, two decoders
// - code 100 picks generator, 101 pin
// - code 111 NRZI, 110 FM
// - reset: disabled, pin source, NRZI
// - NRZI: equal clocks, mid-cell sampling
// - FM: transmit lags receive quarter cycle
// - code 001 enables, or restarts search
// - data sampled whenever loop enabled
// - FM: two missed cells force search
// - search holds counter until boundary edge
// - NRZI: edge near 15/16 no correction
// - NRZI: late edge lengthens next cycle
// - NRZI: early edge shortens next cycle
// - no edge means no adjustment next
// - correct by skipping or repeating count 5
// - NRZI search: count 16, outputs high
// - missing flags unused in NRZI mode
// - FM: 32 counts span two cells
// - FM missing flags latch, clear on commands
// - FM search: count 16, outputs low
`timescale 1ns/1ps
`include "dpl_consts.svh"
module dpl_top (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // command field
  input  wire logic       cmd_valid,
  input  wire logic [2:0] cmd_code,
  // reference sources and data
  input  wire logic       baud_rate_gen,
  input  wire logic       rx_tx_clock_pin,
  input  wire logic       rxd,
  // recovered clocks
  output logic            pll_rx_clk,
  output logic            pll_tx_clk,
  // status
  output logic            pll_enabled,
  output logic            pll_searching,
  output logic            src_is_brg,
  output logic            mode_is_fm,
  output logic            one_clock_missing,
  output logic            two_clocks_missing
);
  import dpl_pkg::*;
  // ==========================================
  // how the loop behaves
  // one count per rise of the chosen reference;
  // the reference low phase is the second half
  // of a count, which splits counts 15 and 16
  // nrzi: 32 counts per cell, clocks high 16..31
  // fm: 32 counts span two cells; only edges in
  // the mid 12 to mid 19 window steer the count
  // corrections wait for the next wrap to 0 and
  // touch count 5 only, so nrzi and fm transmit high phases stay fixed
  // the latest classified edge in a cycle wins
  // auto search is taken at count 2, where both
  // fm clocks are already low: no glitch at entry
  // auto search keeps the missing flags, so that
  // software can still see why lock was lost
  // a flag set and a reset-missing clear in one cycle: set wins
  // any other command wins over the datapath in one cycle
  // limitation: source and mode changes act at
  // once; software must disable the loop first,
  // or a narrow reference pulse may upset a count
  // limitation: edges are seen at core_clk rate,
  // so each reference phase needs one core cycle
  // the first edge after search is trusted as a
  // boundary; a data edge there only delays lock
  // trade-off: every state bit sits in one struct,
  // so the clocks and flags come from the same flops
  // ==========================================
  // declarations
  dpl_core_t s_reg;     // all loop state
  dpl_core_t s_next;    // next loop state
  dpl_smp_if sif ();    // sampler link
  logic      e_nc;      // edge in no-change zone
  logic      e_long;    // edge calls for lengthen
  logic      e_short;   // edge calls for shorten
  logic      e_win;     // edge inside FM window
  logic      e_ign;     // edge FM ignores
  logic      win_hit;   // window seen incl. now
  logic      set_one;   // one-miss event now
  logic      set_two;   // two-miss event now
  // ==========================================
  // input sampler and edge detector
  dpl_sampler u_smp (
    .core_clk        (core_clk),
    .rst             (rst),
    .baud_rate_gen   (baud_rate_gen),
    .rx_tx_clock_pin (rx_tx_clock_pin),
    .rxd             (rxd),
    .sif             (sif.smp)
  );
  // control back to the sampler comes from flops
  assign sif.src_brg = s_reg.src_brg;
  assign sif.enable  = (s_reg.st != DPL_OFF);
  // ==========================================
  // edge position classification
  always_comb begin
    // second half of 15 or first half of 16
    e_nc = ((s_reg.cnt == `DPL_CNT_NC_LO) && sif.half2) ||
           ((s_reg.cnt == `DPL_CNT_NC_HI) && !sif.half2);
    // late: from mid 16 to end of 31
    e_long = ((s_reg.cnt == `DPL_CNT_NC_HI) && sif.half2) ||
             (s_reg.cnt > `DPL_CNT_NC_HI);
    // early: from 0 to mid 15
    e_short = (s_reg.cnt < `DPL_CNT_NC_LO) ||
              ((s_reg.cnt == `DPL_CNT_NC_LO) && !sif.half2);
    // FM window runs mid 12 to mid 19
    e_win = ((s_reg.cnt == `DPL_FM_WIN_LO) && sif.half2) ||
            ((s_reg.cnt > `DPL_FM_WIN_LO) &&
             (s_reg.cnt < `DPL_FM_WIN_HI)) ||
            ((s_reg.cnt == `DPL_FM_WIN_HI) && !sif.half2);
    // data transitions outside window are ignored
    e_ign = !e_win;
    win_hit = s_reg.win_seen | (sif.rxd_edge & e_win);
  end
  // ==========================================
  // next state of the loop
  always_comb begin
    s_next = s_reg;
    // miss events of this cycle, for set-wins
    set_one = 1'b0;
    set_two = 1'b0;
    unique case (s_reg.st)
      // held, no edge detection
      DPL_OFF: begin
        // edge detector off, so no data edge arrives
        s_next.cnt = `DPL_CNT_HOLD;
      end
      // counter held at 16 waiting for an edge
      DPL_SRCH: begin
        s_next.cnt = `DPL_CNT_HOLD;
        if (sif.rxd_edge) begin
          // first edge taken as a cell boundary
          s_next.st = DPL_RUN;
          // in fm that boundary also counts as the window edge
          s_next.win_seen = s_reg.fm;
        end
      end
      // locked or locking: count and correct
      DPL_RUN: begin
        // record a correction for the next cycle
        if (sif.rxd_edge) begin
          if (!s_reg.fm) begin
            // nrzi: every edge steers the count
            if (e_nc) begin
              s_next.corr_req = DPL_C_NONE;
            end else if (e_long) begin
              s_next.corr_req = DPL_C_LONG;
            end else if (e_short) begin
              s_next.corr_req = DPL_C_SHORT;
            end
          end else if (!e_ign) begin
            // fm: window edge, boundary found
            s_next.win_seen = 1'b1;
            if (e_nc) begin
              s_next.corr_req = DPL_C_NONE;
            end else if (e_long) begin
              s_next.corr_req = DPL_C_LONG;
            end else begin
              s_next.corr_req = DPL_C_SHORT;
            end
          end
        end
        // one count per reference rising edge
        if (sif.ref_rise) begin
          // FM window closes at count 19
          if (s_reg.fm && (s_reg.cnt == `DPL_FM_WIN_HI)) begin
            if (!win_hit) begin
              // second miss in a row: line error
              if (s_reg.miss_prev) begin
                s_next.two_mis   = 1'b1;
                s_next.srch_pend = 1'b1;
                set_two          = 1'b1;
              end
              // any miss latches the one flag
              s_next.one_mis   = 1'b1;
              s_next.miss_prev = 1'b1;
              set_one          = 1'b1;
            end else begin
              // boundary seen: streak broken
              s_next.miss_prev = 1'b0;
            end
            s_next.win_seen = 1'b0;
          end
          // counter step with count 5 adjustment
          if ((s_reg.cnt == `DPL_CNT_ADJ) &&
              (s_reg.corr_act == DPL_C_LONG) &&
              !s_reg.dup_done) begin
            // repeat count 5: low phase longer
            s_next.dup_done = 1'b1;
          end else if ((s_reg.cnt == `DPL_CNT_PRE) &&
                       (s_reg.corr_act == DPL_C_SHORT)) begin
            // skip count 5: low phase shorter
            s_next.cnt = `DPL_CNT_SKIP;
          end else if (s_reg.cnt == `DPL_CNT_MAX) begin
            // new cycle takes last cycle's verdict
            s_next.cnt      = `DPL_CNT_ZERO;
            s_next.corr_act = s_next.corr_req;
            s_next.corr_req = DPL_C_NONE;
            s_next.dup_done = 1'b0;
          end else begin
            s_next.cnt = s_reg.cnt + 5'h01;
          end
          // search decision at count 2, both clocks low
          if (s_reg.srch_pend && (s_reg.cnt == `DPL_CNT_DEC)) begin
            // drop any pending correction, start clean
            s_next.st        = DPL_SRCH;
            s_next.cnt       = `DPL_CNT_HOLD;
            s_next.srch_pend = 1'b0;
            s_next.miss_prev = 1'b0;
            s_next.win_seen  = 1'b0;
            s_next.corr_req  = DPL_C_NONE;
            s_next.corr_act  = DPL_C_NONE;
            s_next.dup_done  = 1'b0;
          end
        end
      end
      default: begin
        // illegal code: fall back to disabled
        s_next.st  = DPL_OFF;
        s_next.cnt = `DPL_CNT_HOLD;
      end
    endcase
    // ----------------------------------------
    // software commands override the datapath, except the missing-flag reset
    if (cmd_valid) begin
      unique case (cmd_code)
        `DPL_CMD_SEARCH: begin
          // enable, or restart hunting if enabled
          s_next.st        = DPL_SRCH;
          s_next.cnt       = `DPL_CNT_HOLD;
          s_next.one_mis   = 1'b0;
          s_next.two_mis   = 1'b0;
          s_next.srch_pend = 1'b0;
          s_next.miss_prev = 1'b0;
          s_next.win_seen  = 1'b0;
          s_next.corr_req  = DPL_C_NONE;
          s_next.corr_act  = DPL_C_NONE;
          s_next.dup_done  = 1'b0;
        end
        // disable parks the counter and clears flags
        `DPL_CMD_DISABLE: begin
          s_next.st        = DPL_OFF;
          s_next.cnt       = `DPL_CNT_HOLD;
          s_next.one_mis   = 1'b0;
          s_next.two_mis   = 1'b0;
          s_next.srch_pend = 1'b0;
          s_next.miss_prev = 1'b0;
          s_next.win_seen  = 1'b0;
          s_next.corr_req  = DPL_C_NONE;
          s_next.corr_act  = DPL_C_NONE;
          s_next.dup_done  = 1'b0;
        end
        `DPL_CMD_RST_MIS: begin
          // clear, but a miss found this cycle still sets
          s_next.one_mis = set_one;
          s_next.two_mis = set_two;
        end
        // source and mode: safe only while disabled
        `DPL_CMD_SRC_BRG: begin
          s_next.src_brg = 1'b1;
        end
        `DPL_CMD_SRC_PIN: begin
          s_next.src_brg = 1'b0;
        end
        // fm decoders take over at once
        `DPL_CMD_FM: begin
          s_next.fm = 1'b1;
        end
        `DPL_CMD_NRZI: begin
          s_next.fm        = 1'b0;
          // latches are meaningless in NRZI
          s_next.one_mis   = 1'b0;
          s_next.two_mis   = 1'b0;
          s_next.srch_pend = 1'b0;
        end
        default: begin
          // null command: nothing changes
          s_next.st = s_next.st;
        end
      endcase
    end
    // ----------------------------------------
    // output decoders from the next count;
    // disabled and search both hold count 16
    if (!s_next.fm) begin
      // identical clocks, high 16..31
      s_next.rx_out = s_next.cnt[`DPL_BIT_NRZI];
      s_next.tx_out = s_next.cnt[`DPL_BIT_NRZI];
    end else begin
      // search in fm sits at 16: both clocks low
      // receive edges at quarter points of a cell
      s_next.rx_out = s_next.cnt[`DPL_BIT_FM_A] ^
                      s_next.cnt[`DPL_BIT_FM_B];
      // transmit lags by four counts
      s_next.tx_out = s_next.cnt[`DPL_BIT_FM_A];
    end
  end
  // ==========================================
  // state register; reset gives pin, NRZI, off
  // reset branch holds constants only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg.st        <= DPL_OFF;
      s_reg.cnt       <= `DPL_CNT_HOLD;
      s_reg.corr_req  <= DPL_C_NONE;
      s_reg.corr_act  <= DPL_C_NONE;
      s_reg.dup_done  <= 1'b0;
      s_reg.src_brg   <= 1'b0;
      s_reg.fm        <= 1'b0;
      s_reg.win_seen  <= 1'b0;
      s_reg.miss_prev <= 1'b0;
      s_reg.one_mis   <= 1'b0;
      s_reg.two_mis   <= 1'b0;
      s_reg.srch_pend <= 1'b0;
      // clocks high: disabled loop sits at 16 in nrzi
      s_reg.rx_out    <= 1'b1;
      s_reg.tx_out    <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
  // ==========================================
  // outputs straight from the state flops
  // status decodes read the state flops only
  assign pll_rx_clk         = s_reg.rx_out;
  assign pll_tx_clk         = s_reg.tx_out;
  assign pll_enabled        = (s_reg.st != DPL_OFF);
  assign pll_searching      = (s_reg.st != DPL_RUN);
  assign src_is_brg         = s_reg.src_brg;
  assign mode_is_fm         = s_reg.fm;
  assign one_clock_missing  = s_reg.one_mis;
  assign two_clocks_missing = s_reg.two_mis;
endmodule : dpl_top

// ### verif/dpl_line_model.sv
// far-side model: reference sources and receive data line
`timescale 1ns/1ps
module dpl_line_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // bench controls
  input  wire logic flip,
  input  wire logic stream,
  // lines into the loop
  output logic      baud_rate_gen,
  output logic      rx_tx_clock_pin,
  output logic      rxd
);
  logic [5:0] div_reg; // free cycle count
  logic [2:0] pin_reg; // pin divider, period 6
  // ==========================================
  // lines move just after the rising edge, like any synchronous source
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_reg <= 6'h00;
      pin_reg <= 3'h0;
      rxd     <= 1'b0;
    end else begin
      div_reg <= div_reg + 6'h01;
      pin_reg <= (pin_reg == 3'h5) ? 3'h0 : pin_reg + 3'h1;
      // stream: one edge per 16 generator periods, an FM cell boundary
      if (flip || (stream && div_reg == 6'h3f)) begin
        rxd <= ~rxd;
      end
    end
  end
  // periods 4 and 6 differ, so the chosen source shows in the output
  assign baud_rate_gen   = div_reg[1];
  assign rx_tx_clock_pin = (pin_reg < 3'h3);
endmodule : dpl_line_model

// ### verif/dpl_top_assertions.sv
// port-level checker for the clock recovery loop
`timescale 1ns/1ps
`include "dpl_consts.svh"
module dpl_chk (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // command field
  input wire logic       cmd_valid,
  input wire logic [2:0] cmd_code,
  // watched outputs
  input wire logic       pll_rx_clk,
  input wire logic       pll_tx_clk,
  input wire logic       pll_enabled,
  input wire logic       pll_searching,
  input wire logic       src_is_brg,
  input wire logic       mode_is_fm,
  input wire logic       one_clock_missing,
  input wire logic       two_clocks_missing
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // command taken, and search held over two edges (outputs lag one)
  sequence s_cmd(logic [2:0] c);
    cmd_valid && cmd_code == c;
  endsequence
  sequence s_held(logic fm);
    (pll_searching && mode_is_fm == fm)[*2];
  endsequence
  a_src_brg : assert property (s_cmd(`DPL_CMD_SRC_BRG) |=> src_is_brg)
    else $error("generator source not taken");
  a_src_pin : assert property (s_cmd(`DPL_CMD_SRC_PIN) |=> !src_is_brg)
    else $error("pin source not taken");
  a_mode_fm : assert property (s_cmd(`DPL_CMD_FM) |=> mode_is_fm)
    else $error("fm mode not taken");
  a_mode_nrzi : assert property (s_cmd(`DPL_CMD_NRZI) |=> !mode_is_fm)
    else $error("nrzi mode not taken");
  a_null_code : assert property (s_cmd(`DPL_CMD_NULL)
    |=> $stable({src_is_brg, mode_is_fm}))
    else $error("null code changed state");
  a_search_cmd : assert property (s_cmd(`DPL_CMD_SEARCH) |=> pll_enabled && pll_searching
    && !one_clock_missing && !two_clocks_missing)
    else $error("search command not obeyed");
  a_nrzi_equal : assert property (!mode_is_fm && !$past(mode_is_fm)
    |-> pll_rx_clk == pll_tx_clk)
    else $error("nrzi clocks differ");
  a_nrzi_held : assert property (s_held(1'b0) |-> pll_rx_clk && pll_tx_clk)
    else $error("nrzi search outputs not high");
  a_fm_held : assert property (s_held(1'b1) |-> !pll_rx_clk && !pll_tx_clk)
    else $error("fm search outputs not low");
  a_fm_lag : assert property (mode_is_fm && $rose(pll_tx_clk) |-> pll_rx_clk)
    else $error("fm transmit clock not lagging");
  a_nrzi_no_flags : assert property (!mode_is_fm
    |-> !one_clock_missing && !two_clocks_missing)
    else $error("missing flag in nrzi");
  a_miss_search : assert property ($rose(two_clocks_missing) |-> ##[0:200] pll_searching)
    else $error("no search after two misses");
  a_two_has_one : assert property (two_clocks_missing |-> one_clock_missing)
    else $error("two flag without one flag");
  a_flag_clear : assert property (s_cmd(`DPL_CMD_RST_MIS) && pll_searching
    |=> !one_clock_missing && !two_clocks_missing)
    else $error("flags not cleared");
endmodule : dpl_chk
bind dpl_top dpl_chk u_chk (
  .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .pll_rx_clk(pll_rx_clk), .pll_tx_clk(pll_tx_clk), .pll_enabled(pll_enabled),
  .pll_searching(pll_searching), .src_is_brg(src_is_brg), .mode_is_fm(mode_is_fm),
  .one_clock_missing(one_clock_missing), .two_clocks_missing(two_clocks_missing)
);

// ### verif/dpl_top_tb.sv
// self-checking bench for the clock recovery loop
`timescale 1ns/1ps
`include "dpl_consts.svh"
module dpl_top_tb;
  logic       core_clk  = 1'b0; // 25 MHz
  logic       rst       = 1'b1; // async, active high
  logic       cmd_valid = 1'b0; // command strobe
  logic [2:0] cmd_code  = 3'h0; // command field
  logic       flip      = 1'b0; // one data edge
  logic       stream    = 1'b0; // FM cell edges
  logic       baud_rate_gen, rx_tx_clock_pin, rxd;
  logic       pll_rx_clk, pll_tx_clk, pll_enabled, pll_searching;
  logic       src_is_brg, mode_is_fm, one_clock_missing, two_clocks_missing;
  int         n_errors  = 0; // mismatches
  int         checked   = 0; // comparisons
  dpl_top u_dut (
    .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .baud_rate_gen(baud_rate_gen), .rx_tx_clock_pin(rx_tx_clock_pin), .rxd(rxd),
    .pll_rx_clk(pll_rx_clk), .pll_tx_clk(pll_tx_clk), .pll_enabled(pll_enabled),
    .pll_searching(pll_searching), .src_is_brg(src_is_brg), .mode_is_fm(mode_is_fm),
    .one_clock_missing(one_clock_missing), .two_clocks_missing(two_clocks_missing));
  dpl_line_model u_line (
    .core_clk(core_clk), .rst(rst), .flip(flip), .stream(stream),
    .baud_rate_gen(baud_rate_gen), .rx_tx_clock_pin(rx_tx_clock_pin), .rxd(rxd));
  // ==========================================
  // helpers: compare, command, one data edge, wait on the receive clock
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic send(input logic [2:0] c);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_code  = c;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    @(negedge core_clk);
  endtask : send
  task automatic toggle_rxd;
    @(negedge core_clk);
    flip = 1'b1;
    @(negedge core_clk);
    flip = 1'b0;
  endtask : toggle_rxd
  task automatic wait_rx(input logic v);
    int k;
    k = 0;
    while (pll_rx_clk !== v && k < 400) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 400) check("rx_level", pll_rx_clk, v);
  endtask : wait_rx
  // from the next falling edge: three lows summed, each high exact
  task automatic meas(input int hi, input int lo_sum);
    int lo;
    int n;
    lo = 0;
    wait_rx(1'b1);
    wait_rx(1'b0);
    repeat (3) begin
      for (n = 0; pll_rx_clk === 1'b0 && n < 400; n++) @(negedge core_clk);
      lo += n;
      for (n = 0; pll_rx_clk === 1'b1 && n < 400; n++) @(negedge core_clk);
      check("high_time", n, hi);
    end
    check("low_sum", lo, lo_sum);
  endtask : meas
  // ==========================================
  // scenarios
  task automatic t_reset;
    check("enabled", pll_enabled, 1'b0);
    check("src_mode", {src_is_brg, mode_is_fm}, 2'b00);
    check("clocks", {pll_rx_clk, pll_tx_clk}, 2'b11);
  endtask : t_reset
  task automatic t_codes;
    logic [2:0] code [7];
    logic [1:0] exp [7];
    code = '{`DPL_CMD_SRC_BRG, `DPL_CMD_FM, `DPL_CMD_NULL, `DPL_CMD_SRC_PIN,
             `DPL_CMD_NRZI, `DPL_CMD_RST_MIS, `DPL_CMD_DISABLE};
    exp  = '{2'b10, 2'b11, 2'b11, 2'b01, 2'b00, 2'b00, 2'b00};
    foreach (code[i]) begin
      send(code[i]);
      check("src_mode", {src_is_brg, mode_is_fm}, exp[i]);
      check("enabled", pll_enabled, 1'b0);
    end
  endtask : t_codes
  // pin source after reset: 16 counts of 6 cycles per half
  task automatic t_nrzi_pin;
    send(`DPL_CMD_SEARCH);
    check("enabled", pll_enabled, 1'b1);
    repeat (200) @(negedge core_clk);
    check("held", {pll_searching, pll_rx_clk}, 2'b11);
    toggle_rxd();
    repeat (3) @(negedge core_clk);
    check("locked", pll_searching, 1'b0);
    meas(96, 288);
  endtask : t_nrzi_pin
  // early edge shortens, late edge lengthens, by one 4-cycle count
  task automatic t_nrzi_corr;
    send(`DPL_CMD_DISABLE);
    send(`DPL_CMD_SRC_BRG);
    send(`DPL_CMD_NRZI);
    send(`DPL_CMD_SEARCH);
    toggle_rxd();
    wait_rx(1'b0);
    repeat (32) @(negedge core_clk);
    toggle_rxd();
    meas(64, 188);
    wait_rx(1'b1);
    repeat (32) @(negedge core_clk);
    toggle_rxd();
    meas(64, 196);
    send(`DPL_CMD_SEARCH);
    check("restart", {pll_searching, pll_rx_clk, pll_tx_clk}, 3'b111);
  endtask : t_nrzi_corr
  // FM lock on a clean stream, then loss of edges forces search
  task automatic t_fm;
    int k;
    send(`DPL_CMD_DISABLE);
    send(`DPL_CMD_FM);
    send(`DPL_CMD_SEARCH);
    check("fm_held", {pll_rx_clk, pll_tx_clk}, 2'b00);
    stream = 1'b1;
    repeat (1000) @(negedge core_clk);
    check("fm_lock", {pll_searching, one_clock_missing}, 2'b00);
    stream = 1'b0;
    for (k = 0; pll_searching !== 1'b1 && k < 1000; k++) @(negedge core_clk);
    repeat (2) @(negedge core_clk);
    check("fm_lost", {pll_searching, pll_rx_clk, pll_tx_clk}, 3'b100);
    check("flags", {one_clock_missing, two_clocks_missing}, 2'b11);
    send(`DPL_CMD_RST_MIS);
    check("flags", {one_clock_missing, two_clocks_missing}, 2'b00);
    send(`DPL_CMD_DISABLE);
    send(`DPL_CMD_NRZI);
  endtask : t_fm
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  // ==========================================
  // clock, main sequence, watchdog well past the expected run
  initial forever #20 core_clk = ~core_clk;
  initial begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_codes();
    t_nrzi_pin();
    t_nrzi_corr();
    t_fm();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("Error watchdog expected done seen hang");
    give_verdict();
  end
endmodule : dpl_top_tb
